// [rtl/hsc_consts.vh]
// shared constants for the host controller control block
`ifndef HSC_CONSTS_VH
`define HSC_CONSTS_VH

`define HSC_PS_D0          2'b00
`define HSC_PS_D3          2'b11
`define HSC_FRAME_LIST_LEN 11'd1024
`define HSC_UFRAMES_PER_MS 4'd8
// 125 us microframe at 10 MHz clock
`define HSC_UFRAME_NS      125000
`define HSC_CLK_NS         100
`define HSC_UFRAME_CYC     (`HSC_UFRAME_NS / `HSC_CLK_NS)
// end-of-frame point, cycles before microframe end
`define HSC_EOF_GUARD_CYC  16'd20
`define HSC_STRUCT_RST     32'h0000_0006
`define HSC_SRC_NONE       2'd0
`define HSC_SRC_DEBUG      2'd1
`define HSC_SRC_PERIODIC   2'd2
`define HSC_SRC_ASYNC      2'd3

`endif

// [rtl/hsc_frame_timer.v]
// microframe timer with start-of-frame pulse, frame index and rollover
`timescale 1ns/1ns
`default_nettype none
`include "hsc_consts.vh"
module hsc_frame_timer #(
  parameter UFRAME_CYC = `HSC_UFRAME_CYC
) (
  // clock and reset
  input  wire        clk_in,
  input  wire        reset_n_in,
  input  wire        clear_in,
  // timing outputs
  output reg         sof_out,
  output wire        eof_out,
  output reg  [9:0]  frame_out,
  output reg  [2:0]  uframe_out,
  output reg         rollover_out
);

  reg [15:0] cnt_q;

  assign eof_out = (cnt_q >= (UFRAME_CYC[15:0] - `HSC_EOF_GUARD_CYC));

  always @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cnt_q        <= 16'h0000;
      sof_out      <= 1'b0;
      frame_out    <= 10'h000;
      uframe_out   <= 3'h0;
      rollover_out <= 1'b0;
    end
    else if (clear_in)
    begin
      cnt_q        <= 16'h0000;
      sof_out      <= 1'b0;
      frame_out    <= 10'h000;
      uframe_out   <= 3'h0;
      rollover_out <= 1'b0;
    end
    else
    begin
      sof_out      <= 1'b0;
      rollover_out <= 1'b0;
      if (cnt_q == UFRAME_CYC[15:0] - 16'h0001)
      begin
        cnt_q      <= 16'h0000;
        sof_out    <= 1'b1;
        uframe_out <= uframe_out + 3'h1;
        if (uframe_out == 3'h7)
        begin
          // 10-bit index wraps at the 1024-entry list
          frame_out <= frame_out + 10'h001;
          if (frame_out == 10'h3ff)
            rollover_out <= 1'b1;
        end
      end
      else
        cnt_q <= cnt_q + 16'h0001;
    end
  end

endmodule // hsc_frame_timer
`default_nettype wire

// [rtl/hsc_ctrl.v]
// control logic of the high speed host controller: resets, scheduling, errors, power
`timescale 1ns/1ns
`default_nettype none
`include "hsc_consts.vh"
module hsc_ctrl #(
  parameter       NPORTS     = 6,
  parameter       UFRAME_CYC = `HSC_UFRAME_CYC,
  parameter [31:0] STRUCT_RST = `HSC_STRUCT_RST
) (
  // clock and reset
  input  wire              clk_in,
  input  wire              reset_n_in,
  // system sleep state
  input  wire              sys_sleep_in,
  output wire              pll_enable_out,
  output wire              core_reset_out,
  // software control
  input  wire              host_controller_reset_bit_in,
  input  wire              run_in,
  input  wire              pause_in,
  input  wire              periodic_en_in,
  input  wire              async_en_in,
  input  wire              sys_err_int_en_in,
  input  wire              serr_en_in,
  input  wire              threshold_int_en_in,
  input  wire              rollover_int_en_in,
  input  wire              status_clear_in,
  input  wire [2:0]        test_mode_in,
  input  wire [NPORTS-1:0] test_port_sel_in,
  output reg  [2:0]        port_test_mode_out,
  output reg  [NPORTS-1:0] port_test_en_out,
  // firmware structural parameters
  input  wire              struct_wr_in,
  input  wire [31:0]       struct_data_in,
  output reg  [31:0]       struct_params_out,
  // power state field
  input  wire              pstate_wr_in,
  input  wire [1:0]        pstate_data_in,
  output reg  [1:0]        pstate_out,
  // memory-mapped access check
  input  wire              mmio_req_in,
  output wire              mmio_claim_out,
  output wire              mmio_master_abort_out,
  // packet sources
  input  wire              debug_pend_in,
  input  wire              periodic_pend_in,
  input  wire              async_pend_in,
  input  wire              txn_done_in,
  output reg  [1:0]        grant_out,
  output wire              mem_req_en_out,
  output wire [NPORTS-1:0] port_active_out,
  output wire              sof_out,
  output wire [9:0]        frame_index_out,
  // transaction results
  input  wire              status_posted_in,
  input  wire              last_in_interval_in,
  input  wire              split_intin_in,
  input  wire              split_criteria_met_in,
  input  wire              split_err_in,
  input  wire [1:0]        cerr_in,
  output reg  [1:0]        cerr_out,
  input  wire              csplit_fetch_in,
  input  wire              late_start_fail_in,
  output reg               missed_uframe_out,
  output reg               missed_uframe_wb_out,
  // upstream read completions
  input  wire              rd_cpl_in,
  input  wire              rd_master_abort_in,
  input  wire              rd_target_abort_in,
  // status and configuration bits
  output reg               sys_err_sts_out,
  output reg               halted_out,
  output wire              data_buf_err_out,
  output reg               threshold_sts_out,
  output reg               rollover_sts_out,
  output reg               rcv_master_abort_out,
  output reg               rcv_target_abort_out,
  output reg               sig_sys_err_out,
  // interrupt and wake
  input  wire              wake_event_in,
  output wire              shared_interrupt_line_h_out,
  output wire              pme_out
);

  ////////////////////////////////////////////////////////////////////////////
  // resets and power state

  localparam ST_IDLE   = 4'b0001;
  localparam ST_DEBUG  = 4'b0010;
  localparam ST_PERIOD = 4'b0100;
  localparam ST_ASYNC  = 4'b1000;

  wire in_d3;
  wire d3_to_d0;
  wire core_clr;
  wire mem_clr;
  reg  [3:0] state_q;
  reg  [3:0] state_d;
  reg        fatal_pend_q;
  reg        txn_seen_q;
  wire       t_sof;
  wire       t_eof;
  wire       t_roll;

  assign in_d3          = (pstate_out == `HSC_PS_D3);
  assign d3_to_d0       = pstate_wr_in && in_d3 && (pstate_data_in == `HSC_PS_D0);
  assign core_clr       = sys_sleep_in || d3_to_d0;
  assign mem_clr        = core_clr || host_controller_reset_bit_in;
  assign pll_enable_out = !sys_sleep_in;
  assign core_reset_out = sys_sleep_in;

  // power state field lives in configuration space, so only the wells reset it
  always @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      pstate_out <= `HSC_PS_D0;
    else if (sys_sleep_in)
      pstate_out <= `HSC_PS_D0;
    else if (pstate_wr_in &&
             (pstate_data_in == `HSC_PS_D0 || pstate_data_in == `HSC_PS_D3))
      pstate_out <= pstate_data_in;
  end

  // firmware-written structural parameters survive both soft resets
  always @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      struct_params_out <= STRUCT_RST;
    else if (struct_wr_in)
      struct_params_out <= struct_data_in;
  end

  assign mmio_claim_out        = mmio_req_in && !in_d3;
  assign mmio_master_abort_out = mmio_req_in && in_d3;

  ////////////////////////////////////////////////////////////////////////////
  // microframe timing

  hsc_frame_timer #(
    .UFRAME_CYC (UFRAME_CYC)
  ) u_timer (
    .clk_in       (clk_in),
    .reset_n_in   (reset_n_in),
    .clear_in     (mem_clr || !run_in),
    .sof_out      (t_sof),
    .eof_out      (t_eof),
    .frame_out    (frame_index_out),
    .uframe_out   (),
    .rollover_out (t_roll)
  );

  // frame start keeps going during pause
  assign sof_out = t_sof && run_in && !halted_out;

  ////////////////////////////////////////////////////////////////////////////
  // packet source scheduler

  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (t_sof && debug_pend_in && !in_d3)
          state_d = ST_DEBUG;
        else if (t_sof && periodic_pend_in && periodic_en_in)
          state_d = ST_PERIOD;
        else if (!t_eof && async_pend_in && async_en_in)
          state_d = ST_ASYNC;
      end
      ST_DEBUG:
      begin
        if (txn_done_in)
          state_d = (periodic_pend_in && periodic_en_in) ? ST_PERIOD : ST_IDLE;
      end
      ST_PERIOD:
      begin
        if (txn_done_in && !(periodic_pend_in && periodic_en_in))
          state_d = ST_IDLE;
      end
      ST_ASYNC:
      begin
        if (txn_done_in || t_eof)
          state_d = ST_IDLE;
      end
      default:
        state_d = ST_IDLE;
    endcase
    if (halted_out || pause_in || !run_in)
      state_d = ST_IDLE;
  end

  always @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      state_q <= ST_IDLE;
    else if (mem_clr)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  always @*
  begin
    case (state_q)
      ST_DEBUG:  grant_out = `HSC_SRC_DEBUG;
      ST_PERIOD: grant_out = `HSC_SRC_PERIODIC;
      ST_ASYNC:  grant_out = `HSC_SRC_ASYNC;
      default:   grant_out = `HSC_SRC_NONE;
    endcase
  end

  // no memory traffic while paused, halted or in debug slot
  assign mem_req_en_out = (state_q == ST_PERIOD || state_q == ST_ASYNC) &&
                          !pause_in && !halted_out;

  genvar gp;
  generate
    for (gp = 0; gp < NPORTS; gp = gp + 1)
    begin : g_port
      if (gp == 0)
      begin : g_dbg
        assign port_active_out[gp] = (state_q != ST_IDLE);
      end
      else
      begin : g_oth
        assign port_active_out[gp] = (state_q == ST_PERIOD) ||
                                     (state_q == ST_ASYNC);
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // test modes

  always @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      port_test_mode_out <= 3'h0;
      port_test_en_out   <= {NPORTS{1'b0}};
    end
    else if (mem_clr)
    begin
      port_test_mode_out <= 3'h0;
      port_test_en_out   <= {NPORTS{1'b0}};
    end
    else
    begin
      port_test_mode_out <= test_mode_in;
      port_test_en_out   <= (test_mode_in != 3'h0) ? test_port_sel_in : {NPORTS{1'b0}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // split transaction bookkeeping

  assign data_buf_err_out = 1'b0;

  always @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cerr_out             <= 2'h0;
      missed_uframe_out    <= 1'b0;
      missed_uframe_wb_out <= 1'b0;
    end
    else
    begin
      missed_uframe_wb_out <= 1'b0;
      if (split_intin_in && !split_criteria_met_in)
        cerr_out <= cerr_in;
      else if (split_err_in && cerr_in != 2'h0)
        cerr_out <= cerr_in - 2'h1;
      else
        cerr_out <= cerr_in;
      if (csplit_fetch_in && !late_start_fail_in)
      begin
        missed_uframe_out    <= 1'b1;
        missed_uframe_wb_out <= 1'b1;
      end
      else if (csplit_fetch_in)
        missed_uframe_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fatal host error and status

  wire rd_abort = rd_cpl_in && (rd_master_abort_in || rd_target_abort_in);

  always @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      sys_err_sts_out   <= 1'b0;
      halted_out        <= 1'b0;
      fatal_pend_q      <= 1'b0;
      txn_seen_q        <= 1'b0;
      threshold_sts_out <= 1'b0;
      rollover_sts_out  <= 1'b0;
    end
    else if (mem_clr)
    begin
      sys_err_sts_out   <= 1'b0;
      halted_out        <= 1'b0;
      fatal_pend_q      <= 1'b0;
      txn_seen_q        <= 1'b0;
      threshold_sts_out <= 1'b0;
      rollover_sts_out  <= 1'b0;
    end
    else
    begin
      // set wins over software clear
      if (rd_abort)
        sys_err_sts_out <= 1'b1;
      else if (status_clear_in)
        sys_err_sts_out <= 1'b0;
      if (status_posted_in && last_in_interval_in)
        threshold_sts_out <= 1'b1;
      else if (status_clear_in)
        threshold_sts_out <= 1'b0;
      if (t_roll)
        rollover_sts_out <= 1'b1;
      else if (status_clear_in)
        rollover_sts_out <= 1'b0;
      // allow one transaction in flight to finish, then halt
      if (rd_abort && !fatal_pend_q)
      begin
        fatal_pend_q <= 1'b1;
        txn_seen_q   <= txn_done_in;
        if (state_q == ST_IDLE)
          halted_out <= 1'b1;
      end
      else if (fatal_pend_q && !halted_out)
      begin
        if (txn_done_in || txn_seen_q || state_q == ST_IDLE)
          halted_out <= 1'b1;
      end
      // run/stop only steers halt while no fatal error holds it
      else if (!fatal_pend_q)
        halted_out <= !run_in;
    end
  end

  // configuration bits survive controller reset, only wells clear them
  always @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rcv_master_abort_out <= 1'b0;
      rcv_target_abort_out <= 1'b0;
      sig_sys_err_out      <= 1'b0;
    end
    else if (sys_sleep_in)
    begin
      rcv_master_abort_out <= 1'b0;
      rcv_target_abort_out <= 1'b0;
      sig_sys_err_out      <= 1'b0;
    end
    else
    begin
      if (rd_cpl_in && rd_master_abort_in)
        rcv_master_abort_out <= 1'b1;
      if (rd_cpl_in && rd_target_abort_in)
        rcv_target_abort_out <= 1'b1;
      if (rd_abort && serr_en_in)
        sig_sys_err_out <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt and wake

  wire int_src = (sys_err_sts_out && sys_err_int_en_in) ||
                 (threshold_sts_out && threshold_int_en_in) ||
                 (rollover_sts_out && rollover_int_en_in);

  assign shared_interrupt_line_h_out = int_src && !in_d3;
  assign pme_out                     = wake_event_in && in_d3;

endmodule // hsc_ctrl
`default_nettype wire

// [dv/hsc_usb_mem_model.sv]
// far side model: usb transfer timing and upstream read completions
`timescale 1ns/1ns
`default_nettype none
module hsc_usb_mem_model (
  // clock
  input  wire logic       clk_in,
  // bench commands
  input  wire logic [1:0] grant_in,
  input  wire logic [3:0] txn_len_in,
  input  wire logic       rd_go_in,
  input  wire logic [1:0] rd_sts_in,
  // answers
  output var logic        txn_done_out = 1'b0,
  output var logic        rd_cpl_out = 1'b0,
  output var logic        rd_mabt_out = 1'b0,
  output var logic        rd_tabt_out = 1'b0
);
  logic [3:0] cnt_q = 4'h0;
  ////////////////////////////////////////////////////////////////
  always @(posedge clk_in)
  begin
    txn_done_out <= 1'b0;
    rd_cpl_out   <= rd_go_in;
    // status means nothing without a completion, so it toggles there
    rd_mabt_out  <= rd_go_in ? rd_sts_in[0] : ~rd_mabt_out;
    rd_tabt_out  <= rd_go_in ? rd_sts_in[1] : ~rd_tabt_out;
    // long txn_len_in makes a slow device
    if (grant_in == 2'd0 || txn_done_out)
      cnt_q <= 4'h0;
    else if (cnt_q == txn_len_in)
    begin
      txn_done_out <= 1'b1;
      cnt_q        <= 4'h0;
    end
    else
      cnt_q <= cnt_q + 4'h1;
  end
endmodule // hsc_usb_mem_model
`default_nettype wire

// [dv/hsc_ctrl_sva.sv]
// assertions on the host controller control block ports
`timescale 1ns/1ns
`default_nettype none
`include "hsc_consts.vh"
module hsc_ctrl_sva #(
  parameter NPORTS = 6
) (
  // clock, reset, control
  input wire logic              clk_in,
  input wire logic              reset_n_in,
  input wire logic              sys_sleep_in,
  input wire logic              host_controller_reset_bit_in,
  input wire logic              pause_in,
  input wire logic              serr_en_in,
  input wire logic              pstate_wr_in,
  input wire logic [1:0]        pstate_data_in,
  input wire logic              mmio_req_in,
  input wire logic              rd_cpl_in,
  input wire logic              rd_master_abort_in,
  input wire logic              rd_target_abort_in,
  // outputs watched
  input wire logic              pll_enable_out,
  input wire logic              core_reset_out,
  input wire logic [1:0]        pstate_out,
  input wire logic              mmio_master_abort_out,
  input wire logic [1:0]        grant_out,
  input wire logic [NPORTS-1:0] port_active_out,
  input wire logic              mem_req_en_out,
  input wire logic              sys_err_sts_out,
  input wire logic              halted_out,
  input wire logic              sig_sys_err_out,
  input wire logic              data_buf_err_out,
  input wire logic              shared_interrupt_line_h_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  ////////////////////////////////////////////////////////////////
  a_sleep_pll_off:
    assert property (sys_sleep_in |-> !pll_enable_out && core_reset_out)
    else $error("pll or core reset wrong in sleep");
  a_no_buf_err:
    assert property (!data_buf_err_out)
    else $error("data buffer error raised");
  a_d3_irq_quiet:
    assert property (pstate_out == `HSC_PS_D3 |-> !shared_interrupt_line_h_out)
    else $error("interrupt in D3");
  a_d3_mmio_abort:
    assert property (mmio_req_in && pstate_out == `HSC_PS_D3 |-> mmio_master_abort_out)
    else $error("mmio not aborted in D3");
  a_pstate_bad_hold:
    assert property (pstate_wr_in && (pstate_data_in == 2'b01 || pstate_data_in == 2'b10)
      && !sys_sleep_in |=> $stable(pstate_out))
    else $error("illegal power state taken");
  a_abort_fatal_sts:
    assert property (rd_cpl_in && (rd_master_abort_in || rd_target_abort_in)
      && !host_controller_reset_bit_in && !sys_sleep_in && !pstate_wr_in |=> sys_err_sts_out)
    else $error("abort not fatal");
  a_abort_idle_halt:
    assert property (rd_cpl_in && (rd_master_abort_in || rd_target_abort_in)
      && grant_out == `HSC_SRC_NONE && !host_controller_reset_bit_in && !sys_sleep_in
      && !pstate_wr_in |=> halted_out)
    else $error("idle controller not halted after abort");
  a_serr_gated:
    assert property ($rose(sig_sys_err_out) |-> $past(serr_en_in))
    else $error("system error signalled while disabled");
  a_debug_port0:
    assert property (grant_out == `HSC_SRC_DEBUG
      |-> port_active_out == {{(NPORTS-1){1'b0}}, 1'b1})
    else $error("debug traffic off port 0");
  a_pause_no_mem:
    assert property (pause_in && $past(pause_in) |-> !mem_req_en_out
      && grant_out != `HSC_SRC_PERIODIC && grant_out != `HSC_SRC_ASYNC)
    else $error("memory access while paused");
endmodule // hsc_ctrl_sva

bind hsc_ctrl hsc_ctrl_sva #(.NPORTS(NPORTS)) i_hsc_ctrl_sva (.*);
`default_nettype wire

// [dv/hsc_ctrl_tb_top.sv]
// self-checking bench for the host controller control block
`timescale 1ns/1ns
`default_nettype none
`include "hsc_consts.vh"
module hsc_ctrl_tb_top;
  localparam int UF = 40;
  logic        clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        sys_sleep_in, host_controller_reset_bit_in, run_in, pause_in;
  logic        periodic_en_in, async_en_in, sys_err_int_en_in, serr_en_in;
  logic        threshold_int_en_in, rollover_int_en_in, status_clear_in;
  logic [2:0]  test_mode_in, port_test_mode_out;
  logic [5:0]  test_port_sel_in, port_test_en_out, port_active_out, sq;
  logic        struct_wr_in, pstate_wr_in, mmio_req_in, mmio_claim_out;
  logic [31:0] struct_data_in, struct_params_out;
  logic [1:0]  pstate_data_in, pstate_out, grant_out, cerr_in, cerr_out, lg;
  logic        pll_enable_out, core_reset_out, mmio_master_abort_out;
  logic        debug_pend_in, periodic_pend_in, async_pend_in, txn_done_in;
  logic        mem_req_en_out, sof_out;
  logic [9:0]  frame_index_out, fi;
  logic        status_posted_in, last_in_interval_in, split_intin_in;
  logic        split_criteria_met_in, split_err_in, csplit_fetch_in;
  logic        late_start_fail_in, missed_uframe_out, missed_uframe_wb_out;
  logic        rd_cpl_in, rd_master_abort_in, rd_target_abort_in;
  logic        sys_err_sts_out, halted_out, data_buf_err_out, threshold_sts_out;
  logic        rollover_sts_out, rcv_master_abort_out, rcv_target_abort_out;
  logic        sig_sys_err_out, wake_event_in, shared_interrupt_line_h_out, pme_out;
  logic        rd_go = 1'b0;
  logic [1:0]  rd_sts = 2'b00;
  logic [31:0] sp = 32'h1234_5678;
  int          i;
  int          checked = 0;
  int          n_mismatch = 0;
  ////////////////////////////////////////////////////////////////
  hsc_ctrl #(.UFRAME_CYC(UF)) i_hsc_ctrl (.*);
  hsc_usb_mem_model i_hsc_usb_mem_model (
    .clk_in       (clk_in),
    .grant_in     (grant_out),
    .txn_len_in   (4'h3),
    .rd_go_in     (rd_go),
    .rd_sts_in    (rd_sts),
    .txn_done_out (txn_done_in),
    .rd_cpl_out   (rd_cpl_in),
    .rd_mabt_out  (rd_master_abort_in),
    .rd_tabt_out  (rd_target_abort_in)
  );
  always #50 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic pls(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic pwr(input logic [1:0] v);
    pstate_data_in = v;
    pls(pstate_wr_in);
  endtask
  // completion lands one edge after the model sees rd_go
  task automatic abort(input logic [1:0] s);
    rd_sts = s;
    pls(rd_go);
    cyc(1);
  endtask
  task automatic wait_sof();
    for (int k = 0; sof_out !== 1'b1; k++)
    begin
      if (k > 3 * UF)
      begin
        n_mismatch++;
        end_sim();
      end
      cyc(1);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    {sys_sleep_in, host_controller_reset_bit_in, pause_in, sys_err_int_en_in} = '0;
    {serr_en_in, threshold_int_en_in, rollover_int_en_in, status_clear_in} = '0;
    {test_mode_in, test_port_sel_in, struct_wr_in, struct_data_in} = '0;
    {pstate_wr_in, pstate_data_in, mmio_req_in, debug_pend_in} = '0;
    {periodic_pend_in, async_pend_in, status_posted_in, last_in_interval_in} = '0;
    {split_intin_in, split_criteria_met_in, split_err_in, cerr_in} = '0;
    {csplit_fetch_in, late_start_fail_in, wake_event_in} = '0;
    {run_in, periodic_en_in, async_en_in} = 3'b111;
    repeat (12) @(posedge clk_in);
    @(negedge clk_in);
    reset_n_in = 1'b1;
    cyc(2);
    chk(struct_params_out, `HSC_STRUCT_RST);
    chk(pstate_out, `HSC_PS_D0);
    $display("test reset done");
    struct_data_in = sp;
    pls(struct_wr_in);
    sys_err_int_en_in = 1'b1;
    abort(2'b01);
    chk(sys_err_sts_out, 1'b1);
    chk(rcv_master_abort_out, 1'b1);
    chk(rcv_target_abort_out, 1'b0);
    chk(sig_sys_err_out, 1'b0);
    chk(halted_out, 1'b1);
    chk(shared_interrupt_line_h_out, 1'b1);
    pls(host_controller_reset_bit_in);
    chk(sys_err_sts_out, 1'b0);
    chk(rcv_master_abort_out, 1'b1);
    chk(struct_params_out, sp);
    {sys_err_int_en_in, serr_en_in} = 2'b01;
    abort(2'b10);
    chk(rcv_target_abort_out, 1'b1);
    chk(sig_sys_err_out, 1'b1);
    chk(shared_interrupt_line_h_out, 1'b0);
    $display("test abort done");
    sys_err_int_en_in = 1'b1;
    pwr(2'b11);
    chk(shared_interrupt_line_h_out, 1'b0);
    {wake_event_in, mmio_req_in} = 2'b11;
    cyc(1);
    chk(pme_out, 1'b1);
    chk(mmio_master_abort_out, 1'b1);
    chk(mmio_claim_out, 1'b0);
    wake_event_in = 1'b0;
    pwr(2'b01);
    pwr(2'b10);
    chk(pstate_out, `HSC_PS_D3);
    pwr(2'b00);
    chk(pstate_out, `HSC_PS_D0);
    chk(sys_err_sts_out, 1'b0);
    chk(struct_params_out, sp);
    chk(mmio_claim_out, 1'b1);
    mmio_req_in = 1'b0;
    $display("test power done");
    // raised at the sof edge so async cannot slip in first
    cyc(1);
    wait_sof();
    {debug_pend_in, periodic_pend_in, async_pend_in} = 3'b111;
    {sq, lg} = '0;
    repeat (30)
    begin
      cyc(1);
      if (grant_out !== lg && grant_out !== 2'd0)
        sq = {sq[3:0], grant_out};
      lg = grant_out;
      if (grant_out === `HSC_SRC_DEBUG)
        chk(port_active_out, 6'h01);
      if (grant_out === `HSC_SRC_DEBUG)
        debug_pend_in = 1'b0;
      if (grant_out === `HSC_SRC_PERIODIC)
        periodic_pend_in = 1'b0;
      if (grant_out === `HSC_SRC_ASYNC)
        async_pend_in = 1'b0;
    end
    chk(sq, 6'h1b);
    wait_sof();
    cyc(25);
    async_pend_in = 1'b1;
    cyc(5);
    chk(grant_out, `HSC_SRC_NONE);
    wait_sof();
    cyc(2);
    chk(grant_out, `HSC_SRC_ASYNC);
    // async stays pending so a leak through pause would show
    pause_in = 1'b1;
    cyc(UF);
    wait_sof();
    chk(mem_req_en_out, 1'b0);
    chk(grant_out, `HSC_SRC_NONE);
    {pause_in, async_pend_in} = 2'b00;
    fi = frame_index_out;
    cyc(`HSC_UFRAMES_PER_MS * UF);
    chk(frame_index_out, 10'(fi + 10'h001));
    $display("test schedule done");
    threshold_int_en_in = 1'b1;
    {status_posted_in, last_in_interval_in} = 2'b11;
    cyc(1);
    {status_posted_in, last_in_interval_in} = 2'b00;
    chk(threshold_sts_out, 1'b1);
    chk(shared_interrupt_line_h_out, 1'b1);
    pls(status_clear_in);
    {csplit_fetch_in, late_start_fail_in} = 2'b11;
    cyc(1);
    chk(missed_uframe_out, 1'b0);
    late_start_fail_in = 1'b0;
    cyc(1);
    csplit_fetch_in = 1'b0;
    chk(missed_uframe_wb_out, 1'b1);
    chk(missed_uframe_out, 1'b1);
    {split_intin_in, split_err_in, cerr_in} = 4'hf;
    cerr_in = 2'd2;
    cyc(1);
    split_intin_in = 1'b0;
    chk(cerr_out, 2'd2);
    $display("test status done");
    run_in = 1'b0;
    test_port_sel_in = 6'h01;
    for (i = 1; i < 6; i++)
    begin
      test_mode_in = i[2:0];
      cyc(1);
      chk(port_test_mode_out, i);
      chk(port_test_en_out, 6'h01);
    end
    sys_sleep_in = 1'b1;
    cyc(1);
    chk(pll_enable_out, 1'b0);
    chk(core_reset_out, 1'b1);
    sys_sleep_in = 1'b0;
    $display("test mode and sleep done");
    end_sim();
  end
endmodule // hsc_ctrl_tb_top
`default_nettype wire
